/* inc/aim_pkg.sv */
// Purpose: shared constants for the analog input selector block
// Assumes: 32-bit AXI4-Lite register bus, byte addresses in the low 8 bits
// Notes: gains are carried in signed quarter-dB units
package aim_pkg;
	localparam int AIM_ADDR_W = 8;
	localparam int AIM_DATA_W = 32;
	localparam int AIM_STRB_W = 4;
	localparam int AIM_BYTE_W = 8;

	// register byte offsets
	localparam logic [7:0] AIM_OFF_SELECTOR = 8'h50;
	localparam logic [7:0] AIM_OFF_GAIN = 8'h58;
	localparam logic [7:0] AIM_OFF_STATUS = 8'h5c;
	localparam logic [7:0] AIM_OFF_POWER = 8'h60;
	localparam logic [7:0] AIM_OFF_SIGNAL = 8'h64;

	// field widths
	localparam int AIM_SEL_W = 15;
	localparam int AIM_GAIN_W = 6;
	localparam int AIM_PWR_W = 4;
	localparam int AIM_SIG_W = 7;
	localparam int AIM_SIG_PWR_W = 5;
	localparam int AIM_POS_W = 4;
	localparam int AIM_NEG_W = 8;
	localparam int AIM_QDB_W = 10;

	// reset values
	localparam logic [AIM_SEL_W-1:0] AIM_SEL_RESET = 15'h0000;
	localparam logic [AIM_GAIN_W-1:0] AIM_GAIN_RESET = 6'h00;
	localparam logic [AIM_PWR_W-1:0] AIM_PWR_RESET = 4'h0;
	localparam logic [AIM_SIG_W-1:0] AIM_SIG_RESET = 7'h00;

	// analog_input_selector fields
	localparam int AIM_SEL_ENABLE_BIT = 14;
	localparam int AIM_SEL_MIC_BIT = 13;
	localparam int AIM_SEL_TEMP_BIT = 12;
	localparam int AIM_SEL_POS_LSB = 8;
	localparam int AIM_SEL_NEG_LSB = 0;

	// amp_power_control fields
	localparam int AIM_PWR_BOOST_GAIN_BIT = 3;
	localparam int AIM_PWR_BOOST_UP_BIT = 2;
	localparam int AIM_PWR_AMP_UP_BIT = 1;
	localparam int AIM_PWR_REF_BIT = 0;

	// signal_path_control fields
	localparam int AIM_SIG_MUTE_BOOST_BIT = 6;
	localparam int AIM_SIG_MUTE_AMP_BIT = 5;

	// status fields
	localparam int AIM_STAT_ACTIVE_BIT = 0;
	localparam int AIM_STAT_MIC_BIT = 1;
	localparam int AIM_STAT_TEMP_BIT = 2;
	localparam int AIM_STAT_POS_LSB = 4;
	localparam int AIM_STAT_NEG_LSB = 8;
	localparam int AIM_STAT_QDB_LSB = 16;

	// gain in quarter-dB: -12dB at code 0, 0.75dB per step, boost adds 26dB
	localparam logic signed [AIM_QDB_W-1:0] AIM_GAIN_MIN_QDB = 10'sh3d0;
	localparam logic signed [AIM_QDB_W-1:0] AIM_GAIN_STEP_QDB = 10'sh003;
	localparam logic signed [AIM_QDB_W-1:0] AIM_GAIN_MAX_QDB = 10'sh08d;
	localparam logic signed [AIM_QDB_W-1:0] AIM_BOOST_QDB = 10'sh068;
	localparam logic [AIM_GAIN_W-1:0] AIM_GAIN_MIN_CODE = 6'h00;
	localparam logic [AIM_GAIN_W-1:0] AIM_GAIN_MAX_CODE = 6'h3f;

	localparam logic [1:0] AIM_RESP_OKAY = 2'h0;
	localparam logic [1:0] AIM_RESP_SLVERR = 2'h2;
endpackage

/* src/aim_switch_decode.sv */
// Purpose: turns the selector word into analog switch closures
// Assumes: selector word is already registered
// Notes: purely combinational
`timescale 1ns/1ps
module aim_switch_decode
	import aim_pkg::*;
(
	input wire logic [aim_pkg::AIM_SEL_W-1:0] selector,
	output logic micPins,
	output logic tempCurrent,
	output logic [aim_pkg::AIM_POS_W-1:0] posPins,
	output logic [aim_pkg::AIM_NEG_W-1:0] negPins
);
	import aim_pkg::*;

	function automatic logic is_one_hot(input logic [AIM_POS_W-1:0] v);
		return (v != '0) && ((v & (v - 1'b1)) == '0);
	endfunction

	logic enable;
	logic [AIM_POS_W-1:0] posField;

	always_comb
	begin
		enable = selector[AIM_SEL_ENABLE_BIT];
		posField = selector[AIM_SEL_POS_LSB +: AIM_POS_W];
		micPins = enable && selector[AIM_SEL_MIC_BIT];
		tempCurrent = enable && selector[AIM_SEL_TEMP_BIT];
		// a pattern that is not one-hot would short odd pins together, so it opens all
		posPins = (enable && is_one_hot(posField)) ? posField : '0;
		negPins = enable ? selector[AIM_SEL_NEG_LSB +: AIM_NEG_W] : '0;
	end
endmodule

/* src/aim_gain_calc.sv */
// Purpose: amplifier and boost gain in quarter-dB and path activity
// Assumes: inputs are register values
// Notes: purely combinational
`timescale 1ns/1ps
module aim_gain_calc
	import aim_pkg::*;
(
	input wire logic [aim_pkg::AIM_GAIN_W-1:0] gainCode,
	input wire logic [aim_pkg::AIM_PWR_W-1:0] powerCtl,
	output logic signed [aim_pkg::AIM_QDB_W-1:0] ampQdb,
	output logic signed [aim_pkg::AIM_QDB_W-1:0] pathQdb,
	output logic active
);
	import aim_pkg::*;

	always_comb
	begin
		// linear in the code, so monotonic from -12dB to 35.25dB
		ampQdb = AIM_GAIN_MIN_QDB + AIM_GAIN_STEP_QDB * $signed(AIM_QDB_W'(gainCode));
		pathQdb = powerCtl[AIM_PWR_BOOST_GAIN_BIT] ? ampQdb + AIM_BOOST_QDB : ampQdb;
		active = powerCtl[AIM_PWR_AMP_UP_BIT] && powerCtl[AIM_PWR_BOOST_UP_BIT];
	end
endmodule

/* src/aim_top.sv */
// Purpose: analog input selector, amplifier gain and boost control behind AXI4-Lite
// Assumes: single clock, synchronous inputs, one outstanding read and write
// Notes: switch and gain outputs follow register writes by one clock
//
// Contract
// - selector enable clear opens every input switch; set follows other fields.
// - bit 13 connects microphone pins to amplifier inputs.
// - bit 12 routes temperature current onto amplifier negative input.
// - one-hot field bits 11..8 connects port B pin 7, 5, 3 or 1 positive.
// - each negative select bit n connects port B pin n independently.
// - six-bit gain code spans -12dB to 35.25dB in 0.75dB steps.
// - gain rises with code; 0x00 lowest, 0x3f highest.
// - path active only when amplifier and boost are both powered.
// - amplifier and boost mute independently via signal path control.
// - boost gives 0dB or 26dB, about 61dB total path maximum.
// - power register: bit3 boost gain, bit2 boost up, bit1 amp up, bit0 bandgap.
`timescale 1ns/1ps
module aim_top
	import aim_pkg::*;
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic awvalid,
	output logic awready,
	input wire logic [aim_pkg::AIM_ADDR_W-1:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [aim_pkg::AIM_DATA_W-1:0] wdata,
	input wire logic [aim_pkg::AIM_STRB_W-1:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [aim_pkg::AIM_ADDR_W-1:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [aim_pkg::AIM_DATA_W-1:0] rdata,
	output logic [1:0] rresp,
	output logic micPinsConnect,
	output logic tempCurrentConnect,
	output logic [aim_pkg::AIM_POS_W-1:0] posPinConnect,
	output logic [aim_pkg::AIM_NEG_W-1:0] negPinConnect,
	output logic ampPowerUp,
	output logic boostPowerUp,
	output logic boostGainHigh,
	output logic refBandgap,
	output logic ampMute,
	output logic boostMute,
	output logic [aim_pkg::AIM_SIG_PWR_W-1:0] pathPowerUps,
	output logic [aim_pkg::AIM_GAIN_W-1:0] ampGainCode,
	output logic signed [aim_pkg::AIM_QDB_W-1:0] ampGainQdb,
	output logic signed [aim_pkg::AIM_QDB_W-1:0] pathGainQdb,
	output logic pathActive
);
	import aim_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic [AIM_DATA_W-1:0] merge_bytes(
		input logic [AIM_DATA_W-1:0] oldVal,
		input logic [AIM_DATA_W-1:0] newVal,
		input logic [AIM_STRB_W-1:0] strb
	);
		logic [AIM_DATA_W-1:0] res;
		res = oldVal;
		for (int i = 0; i < AIM_STRB_W; i++)
		begin
			if (strb[i])
				res[i*AIM_BYTE_W +: AIM_BYTE_W] = newVal[i*AIM_BYTE_W +: AIM_BYTE_W];
		end
		return res;
	endfunction

	function automatic logic is_mapped(input logic [AIM_ADDR_W-1:0] a);
		logic [AIM_ADDR_W-1:0] word;
		word = {a[AIM_ADDR_W-1:2], 2'h0};
		return (word == AIM_OFF_SELECTOR) || (word == AIM_OFF_GAIN) ||
			(word == AIM_OFF_STATUS) || (word == AIM_OFF_POWER) || (word == AIM_OFF_SIGNAL);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// declarations
	logic [AIM_SEL_W-1:0] selector_ff;
	logic [AIM_GAIN_W-1:0] gainCode_ff, gainOut_ff;
	logic [AIM_PWR_W-1:0] powerCtl_ff, powerOut_ff;
	logic [AIM_SIG_W-1:0] sigCtl_ff, sigOut_ff;
	logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
	logic [1:0] bresp_ff, rresp_ff;
	logic [AIM_ADDR_W-1:0] awAddr_ff, wrWord;
	logic [AIM_DATA_W-1:0] wData_ff, rdata_ff, statusWord, readWord;
	logic [AIM_STRB_W-1:0] wStrb_ff;
	logic micPins_ff, tempCurrent_ff, pathActive_ff, writeGo;
	logic [AIM_POS_W-1:0] posPins_ff, nxt_posPins;
	logic [AIM_NEG_W-1:0] negPins_ff, nxt_negPins;
	logic signed [AIM_QDB_W-1:0] ampQdb_ff, pathQdb_ff, nxt_ampQdb, nxt_pathQdb;
	logic nxt_micPins, nxt_tempCurrent, nxt_pathActive;

	////////////////////////////////////////////////////////////////////////////////
	// write channels: address and data are caught in either order
	assign writeGo = !awready_ff && !wready_ff && !bvalid_ff;
	assign wrWord = {awAddr_ff[AIM_ADDR_W-1:2], 2'h0};

	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			awready_ff <= 1'b1;
			wready_ff <= 1'b1;
			bvalid_ff <= 1'b0;
			bresp_ff <= AIM_RESP_OKAY;
			awAddr_ff <= '0;
			wData_ff <= '0;
			wStrb_ff <= '0;
		end
		else
		begin
			if (awvalid && awready_ff)
			begin
				awAddr_ff <= awaddr;
				awready_ff <= 1'b0;
			end
			if (wvalid && wready_ff)
			begin
				wData_ff <= wdata;
				wStrb_ff <= wstrb;
				wready_ff <= 1'b0;
			end
			if (writeGo)
			begin
				bvalid_ff <= 1'b1;
				bresp_ff <= is_mapped(awAddr_ff) ? AIM_RESP_OKAY : AIM_RESP_SLVERR;
			end
			// both readies reopen only after the response is taken
			if (bvalid_ff && bready)
			begin
				bvalid_ff <= 1'b0;
				awready_ff <= 1'b1;
				wready_ff <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// control registers
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			selector_ff <= AIM_SEL_RESET;
			gainCode_ff <= AIM_GAIN_RESET;
			powerCtl_ff <= AIM_PWR_RESET;
			sigCtl_ff <= AIM_SIG_RESET;
		end
		else if (writeGo)
		begin
			case (wrWord)
				AIM_OFF_SELECTOR:
					selector_ff <= AIM_SEL_W'(merge_bytes(AIM_DATA_W'(selector_ff), wData_ff, wStrb_ff));
				AIM_OFF_GAIN:
					gainCode_ff <= AIM_GAIN_W'(merge_bytes(AIM_DATA_W'(gainCode_ff), wData_ff, wStrb_ff));
				AIM_OFF_POWER:
					powerCtl_ff <= AIM_PWR_W'(merge_bytes(AIM_DATA_W'(powerCtl_ff), wData_ff, wStrb_ff));
				AIM_OFF_SIGNAL:
					sigCtl_ff <= AIM_SIG_W'(merge_bytes(AIM_DATA_W'(sigCtl_ff), wData_ff, wStrb_ff));
				default:
					selector_ff <= selector_ff;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read channel
	always_comb
	begin
		statusWord = '0;
		statusWord[AIM_STAT_ACTIVE_BIT] = pathActive_ff;
		statusWord[AIM_STAT_MIC_BIT] = micPins_ff;
		statusWord[AIM_STAT_TEMP_BIT] = tempCurrent_ff;
		statusWord[AIM_STAT_POS_LSB +: AIM_POS_W] = posPins_ff;
		statusWord[AIM_STAT_NEG_LSB +: AIM_NEG_W] = negPins_ff;
		statusWord[AIM_STAT_QDB_LSB +: AIM_QDB_W] = pathQdb_ff;
	end

	always_comb
	begin
		case ({araddr[AIM_ADDR_W-1:2], 2'h0})
			AIM_OFF_SELECTOR:
				readWord = 32'(selector_ff);
			AIM_OFF_GAIN:
				readWord = 32'(gainCode_ff);
			AIM_OFF_STATUS:
				readWord = statusWord;
			AIM_OFF_POWER:
				readWord = 32'(powerCtl_ff);
			AIM_OFF_SIGNAL:
				readWord = 32'(sigCtl_ff);
			default:
				readWord = '0;
		endcase
	end

	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			arready_ff <= 1'b1;
			rvalid_ff <= 1'b0;
			rdata_ff <= '0;
			rresp_ff <= AIM_RESP_OKAY;
		end
		else if (arvalid && arready_ff)
		begin
			arready_ff <= 1'b0;
			rvalid_ff <= 1'b1;
			rdata_ff <= readWord;
			rresp_ff <= is_mapped(araddr) ? AIM_RESP_OKAY : AIM_RESP_SLVERR;
		end
		else if (rvalid_ff && rready)
		begin
			rvalid_ff <= 1'b0;
			arready_ff <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// analog controls, registered so the switches never see decode glitches
	aim_switch_decode switchDecode (
		.selector(selector_ff),
		.micPins(nxt_micPins),
		.tempCurrent(nxt_tempCurrent),
		.posPins(nxt_posPins),
		.negPins(nxt_negPins)
	);

	aim_gain_calc gainCalc (
		.gainCode(gainCode_ff),
		.powerCtl(powerCtl_ff),
		.ampQdb(nxt_ampQdb),
		.pathQdb(nxt_pathQdb),
		.active(nxt_pathActive)
	);

	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			micPins_ff <= 1'b0;
			tempCurrent_ff <= 1'b0;
			posPins_ff <= '0;
			negPins_ff <= '0;
		end
		else
		begin
			micPins_ff <= nxt_micPins;
			tempCurrent_ff <= nxt_tempCurrent;
			posPins_ff <= nxt_posPins;
			negPins_ff <= nxt_negPins;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			powerOut_ff <= AIM_PWR_RESET;
			sigOut_ff <= AIM_SIG_RESET;
			gainOut_ff <= AIM_GAIN_RESET;
			ampQdb_ff <= AIM_GAIN_MIN_QDB;
			pathQdb_ff <= AIM_GAIN_MIN_QDB;
			pathActive_ff <= 1'b0;
		end
		else
		begin
			powerOut_ff <= powerCtl_ff;
			sigOut_ff <= sigCtl_ff;
			gainOut_ff <= gainCode_ff;
			ampQdb_ff <= nxt_ampQdb;
			pathQdb_ff <= nxt_pathQdb;
			pathActive_ff <= nxt_pathActive;
		end
	end

	assign awready = awready_ff;
	assign wready = wready_ff;
	assign bvalid = bvalid_ff;
	assign bresp = bresp_ff;
	assign arready = arready_ff;
	assign rvalid = rvalid_ff;
	assign rdata = rdata_ff;
	assign rresp = rresp_ff;
	assign micPinsConnect = micPins_ff;
	assign tempCurrentConnect = tempCurrent_ff;
	assign posPinConnect = posPins_ff;
	assign negPinConnect = negPins_ff;
	assign boostGainHigh = powerOut_ff[AIM_PWR_BOOST_GAIN_BIT];
	assign boostPowerUp = powerOut_ff[AIM_PWR_BOOST_UP_BIT];
	assign ampPowerUp = powerOut_ff[AIM_PWR_AMP_UP_BIT];
	assign refBandgap = powerOut_ff[AIM_PWR_REF_BIT];
	assign boostMute = sigOut_ff[AIM_SIG_MUTE_BOOST_BIT];
	assign ampMute = sigOut_ff[AIM_SIG_MUTE_AMP_BIT];
	assign pathPowerUps = sigOut_ff[AIM_SIG_PWR_W-1:0];
	assign ampGainCode = gainOut_ff;
	assign ampGainQdb = ampQdb_ff;
	assign pathGainQdb = pathQdb_ff;
	assign pathActive = pathActive_ff;

	////////////////////////////////////////////////////////////////////////////////
	// checks
	sequence seq_sel_write;
		writeGo && (wrWord == AIM_OFF_SELECTOR);
	endsequence
	sequence seq_sel_read;
		arvalid && arready_ff && ({araddr[AIM_ADDR_W-1:2], 2'h0} == AIM_OFF_SELECTOR);
	endsequence
	chk_enable_opens_all: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!selector_ff[AIM_SEL_ENABLE_BIT] |=> (!micPins_ff && !tempCurrent_ff &&
			posPins_ff == '0 && negPins_ff == '0))
		else $error("switch closed while selector disabled");
	chk_mic_pins_follow: assert property (@(posedge sys_clk) disable iff (sys_rst)
		selector_ff[AIM_SEL_ENABLE_BIT] |=> micPins_ff == $past(selector_ff[AIM_SEL_MIC_BIT]))
		else $error("microphone pin switch does not follow its select bit");
	chk_temp_current_route: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(selector_ff[AIM_SEL_ENABLE_BIT] && selector_ff[AIM_SEL_TEMP_BIT]) |=> tempCurrent_ff)
		else $error("temperature current not routed");
	chk_pos_one_hot: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(posPins_ff == '0) || ((posPins_ff & (posPins_ff - 1'b1)) == '0))
		else $error("more than one positive input pin connected");
	chk_pos_pin_seven: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(selector_ff[AIM_SEL_ENABLE_BIT] && selector_ff[AIM_SEL_POS_LSB +: AIM_POS_W] == 4'h8)
			|=> posPins_ff == 4'h8)
		else $error("pin seven not connected to positive input");
	chk_neg_pins_follow: assert property (@(posedge sys_clk) disable iff (sys_rst)
		selector_ff[AIM_SEL_ENABLE_BIT] |=> negPins_ff == $past(selector_ff[AIM_NEG_W-1:0]))
		else $error("negative input pins do not follow select field");
	chk_gain_extremes: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(gainCode_ff == AIM_GAIN_MAX_CODE) ##1 (gainCode_ff == AIM_GAIN_MIN_CODE)
			|=> ampQdb_ff < $past(ampQdb_ff) && ampQdb_ff == AIM_GAIN_MIN_QDB)
		else $error("gain code extremes out of order");
	chk_gain_top: assert property (@(posedge sys_clk) disable iff (sys_rst)
		gainCode_ff == AIM_GAIN_MAX_CODE |=> ampQdb_ff == AIM_GAIN_MAX_QDB)
		else $error("top gain code does not give maximum gain");
	chk_boost_adds: assert property (@(posedge sys_clk) disable iff (sys_rst)
		boostGainHigh |-> pathQdb_ff - ampQdb_ff == AIM_BOOST_QDB)
		else $error("boost gain not added to path gain");
	chk_path_needs_power: assert property (@(posedge sys_clk) disable iff (sys_rst)
		pathActive_ff == (ampPowerUp && boostPowerUp))
		else $error("path activity disagrees with power controls");
	chk_mutes_independent: assert property (@(posedge sys_clk) disable iff (sys_rst)
		$changed(sigCtl_ff[AIM_SIG_MUTE_AMP_BIT]) && $stable(sigCtl_ff[AIM_SIG_MUTE_BOOST_BIT])
			|=> $changed(ampMute) && $stable(boostMute))
		else $error("amplifier mute disturbed the boost mute");
	chk_sel_write_lands: assert property (@(posedge sys_clk) disable iff (sys_rst)
		seq_sel_write |=> selector_ff ==
			$past(AIM_SEL_W'(merge_bytes(AIM_DATA_W'(selector_ff), wData_ff, wStrb_ff))))
		else $error("selector write not stored");
	chk_reserved_reads_zero: assert property (@(posedge sys_clk) disable iff (sys_rst)
		seq_sel_read |=> rvalid_ff && rdata_ff[AIM_DATA_W-1:AIM_SEL_W] == '0)
		else $error("reserved selector bits read nonzero");
endmodule

/* verification/aim_top_tb.sv */
// Purpose: self-checking bench for the analog input selector over AXI4-Lite
// Assumes: one write and one read in flight at most, answers bounded by a timeout loop
// Notes: analog outputs are sampled one clock after the write response
`timescale 1ns/1ps
module aim_top_tb;
	import aim_pkg::*;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic awready, wready, bvalid, arready, rvalid, micPinsConnect, tempCurrentConnect;
	logic ampPowerUp, boostPowerUp, boostGainHigh, refBandgap, ampMute, boostMute, pathActive;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [3:0] posPinConnect;
	logic [7:0] negPinConnect;
	logic [4:0] pathPowerUps;
	logic [5:0] ampGainCode;
	logic signed [9:0] ampGainQdb, pathGainQdb;
	int errorCnt = 0;
	int testsRun = 0;
	logic [5:0] codes [3] = '{6'h00, 6'h17, 6'h3f};
	logic [6:0] sigs [4] = '{7'h20, 7'h40, 7'h60, 7'h1e};
	logic [9:0] eq;

	always #2.5 sys_clk = ~sys_clk;

	aim_top DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .awvalid(awvalid), .awready(awready),
		.awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
		.bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
		.araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.micPinsConnect(micPinsConnect), .tempCurrentConnect(tempCurrentConnect),
		.posPinConnect(posPinConnect), .negPinConnect(negPinConnect), .ampPowerUp(ampPowerUp),
		.boostPowerUp(boostPowerUp), .boostGainHigh(boostGainHigh), .refBandgap(refBandgap),
		.ampMute(ampMute), .boostMute(boostMute), .pathPowerUps(pathPowerUps),
		.ampGainCode(ampGainCode), .ampGainQdb(ampGainQdb), .pathGainQdb(pathGainQdb),
		.pathActive(pathActive));

	////////////////////////////////////////////////////////////////////////////////
	task automatic printVerdict();
		$display("checks %0d, mismatches %0d", testsRun, errorCnt);
		if (errorCnt == 0 && testsRun > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		testsRun++;
		if (got !== exp)
		begin
			errorCnt++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] er);
		int n;
		@(posedge sys_clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 50; n++)
		begin
			@(posedge sys_clk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid)
			begin
				chk("bresp", {30'h0, er}, {30'h0, bresp});
				bready <= 1'b0;
				break;
			end
		end
		if (n == 50)
		begin
			errorCnt++;
			printVerdict();
		end
		// switch and gain outputs follow the register by one more edge
		@(posedge sys_clk);
		#1;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		@(posedge sys_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 50; n++)
		begin
			@(posedge sys_clk);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid)
			begin
				chk("rdata", ed, rdata);
				chk("rresp", {30'h0, er}, {30'h0, rresp});
				rready <= 1'b0;
				break;
			end
		end
		if (n == 50)
		begin
			errorCnt++;
			printVerdict();
		end
	endtask

	task automatic chkSw(input logic m, input logic t, input logic [3:0] p, input logic [7:0] q);
		chk("micPins", {31'h0, m}, {31'h0, micPinsConnect});
		chk("tempCurrent", {31'h0, t}, {31'h0, tempCurrentConnect});
		chk("posPins", {28'h0, p}, {28'h0, posPinConnect});
		chk("negPins", {24'h0, q}, {24'h0, negPinConnect});
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (20) @(posedge sys_clk);
		sys_rst <= 1'b0;
		#1;
		chkSw(1'b0, 1'b0, 4'h0, 8'h00);
		chk("pathGain", 32'h3d0, {22'h0, pathGainQdb});
		rd(AIM_OFF_SELECTOR, 32'h0, AIM_RESP_OKAY);
		rd(AIM_OFF_GAIN, 32'h0, AIM_RESP_OKAY);
		rd(AIM_OFF_POWER, 32'h0, AIM_RESP_OKAY);
		rd(AIM_OFF_SIGNAL, 32'h0, AIM_RESP_OKAY);
		// reserved bits all set, positive field kept one-hot as software must
		wr(AIM_OFF_SELECTOR, 32'hfffff1ff, 4'hf, AIM_RESP_OKAY);
		chkSw(1'b1, 1'b1, 4'h1, 8'hff);
		rd(AIM_OFF_SELECTOR, 32'h000071ff, AIM_RESP_OKAY);
		wr(AIM_OFF_SELECTOR, 32'h000031ff, 4'hf, AIM_RESP_OKAY);
		chkSw(1'b0, 1'b0, 4'h0, 8'h00);
		rd(AIM_OFF_SELECTOR, 32'h000031ff, AIM_RESP_OKAY);
		for (int i = 0; i < 4; i++)
		begin
			wr(AIM_OFF_SELECTOR, 32'h4000 | (32'h100 << i), 4'hf, AIM_RESP_OKAY);
			chkSw(1'b0, 1'b0, 4'h1 << i, 8'h00);
		end
		wr(AIM_OFF_SELECTOR, 32'h000040a5, 4'hf, AIM_RESP_OKAY);
		chkSw(1'b0, 1'b0, 4'h0, 8'ha5);
		wr(AIM_OFF_SELECTOR, 32'h000060ff, 4'h2, AIM_RESP_OKAY);
		chkSw(1'b1, 1'b0, 4'h0, 8'ha5);
		wr(AIM_OFF_POWER, 32'h8, 4'hf, AIM_RESP_OKAY);
		for (int i = 0; i < 3; i++)
		begin
			wr(AIM_OFF_GAIN, {26'h0, codes[i]}, 4'hf, AIM_RESP_OKAY);
			eq = 10'(-48 + 3 * int'(codes[i]));
			chk("gainCode", {26'h0, codes[i]}, {26'h0, ampGainCode});
			chk("ampGain", {22'h0, eq}, {22'h0, ampGainQdb});
			chk("pathGain", {22'h0, eq + 10'd104}, {22'h0, pathGainQdb});
			rd(AIM_OFF_GAIN, {26'h0, codes[i]}, AIM_RESP_OKAY);
		end
		// straight from the top code back to the bottom one
		wr(AIM_OFF_GAIN, 32'h0, 4'hf, AIM_RESP_OKAY);
		chk("ampGainLow", 32'h3d0, {22'h0, ampGainQdb});
		chk("pathGainLow", 32'h038, {22'h0, pathGainQdb});
		for (int p = 0; p < 16; p++)
		begin
			wr(AIM_OFF_POWER, 32'(p), 4'hf, AIM_RESP_OKAY);
			chk("power", 32'(p), {28'h0, boostGainHigh, boostPowerUp, ampPowerUp,
				refBandgap});
			chk("active", 32'((p >> 1) & (p >> 2) & 1), {31'h0, pathActive});
		end
		for (int i = 0; i < 4; i++)
		begin
			wr(AIM_OFF_SIGNAL, {25'h0, sigs[i]}, 4'hf, AIM_RESP_OKAY);
			chk("mutes", {25'h0, sigs[i]}, {25'h0, boostMute, ampMute, pathPowerUps});
		end
		wr(AIM_OFF_POWER, 32'h07, 4'hf, AIM_RESP_OKAY);
		wr(AIM_OFF_SELECTOR, 32'h5000, 4'hf, AIM_RESP_OKAY);
		wr(AIM_OFF_GAIN, 32'h17, 4'hf, AIM_RESP_OKAY);
		chkSw(1'b0, 1'b1, 4'h0, 8'h00);
		rd(AIM_OFF_STATUS, 32'h00150005, AIM_RESP_OKAY);
		wr(AIM_OFF_STATUS, 32'hffffffff, 4'hf, AIM_RESP_OKAY);
		rd(AIM_OFF_STATUS, 32'h00150005, AIM_RESP_OKAY);
		wr(8'h54, 32'hffffffff, 4'hf, AIM_RESP_SLVERR);
		rd(8'h54, 32'h0, AIM_RESP_SLVERR);
		rd(AIM_OFF_SELECTOR, 32'h5000, AIM_RESP_OKAY);
		// reset in mid-run clears the register again
		@(posedge sys_clk);
		sys_rst <= 1'b1;
		repeat (3) @(posedge sys_clk);
		sys_rst <= 1'b0;
		rd(AIM_OFF_SELECTOR, 32'h0, AIM_RESP_OKAY);
		chkSw(1'b0, 1'b0, 4'h0, 8'h00);
		printVerdict();
	end
endmodule
